/* msd_params.svh */
// What this block does
// - Pin high: fetches below 4000 hex internal, from 4000 hex up external.
// - Pin low: every instruction fetch goes to external program memory.
// - Upper RAM by indirect, SFRs by direct; lower 128 bytes take both.
// - RAM 00..1F holds four register banks; bank bits 3 and 4 pick one.
// - RAM bytes 20..2F are also reachable as 128 single bits.
// - Registers 0 and 1 of the active bank serve as indirect pointers.
// - Reset sets stack pointer to 07; push pre-increments; stack anywhere.
// - A 256-byte on-chip RAM sits at the top of external data space.
// - Map-enable clear: every external move uses the external bus.
// - Map-enable set: 8-bit pointer moves hit on-chip RAM, no bus cycle.
// - Map-enable set: 16-bit moves FF00..FFFF on-chip, below stays external.
// - On-chip RAM keeps contents through reset; undefined after power-up.
// - Reset in first cycle of a two-cycle write suppresses the store.
// - Reset in the second cycle of such a write still stores the value.
// - Reset clears map-enable, so on-chip RAM is off until software sets it.
// - Port 0 muxed low address/data, port 2 high address, low strobes.
// - Map-enable clear: 8-bit moves use 256-byte pages set by port 2.
// - On-chip-only accesses leave ports 0, 2 and 3 free for general I/O.
// - Three registers live in a mapped area, reached only with select set.
// - Hardware clears the area select only at reset; otherwise only software writes it.
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH
`define MSD_CODE_LIMIT 16'h4000
`define MSD_XRAM_PAGE 8'hFF
`define MSD_SP_RESET 8'h07
`define MSD_PSW_RESET 8'h00
`define MSD_SYSTEM_CONTROL_RESET 8'h20
`define MSD_SYSTEM_CONTROL_MASK 8'h31
`define MSD_ADDR_SP 8'h81
`define MSD_ADDR_SYSTEM_CONTROL 8'hB1
`define MSD_ADDR_PSW 8'hD0
`define MSD_BIT_ONCHIP_RAM_MAP_ENABLE 0
`define MSD_BIT_SFR_AREA_SELECT 4
`define MSD_BIT_RS0 3
`define MSD_BIT_RS1 4
`define MSD_BITAREA_HI 4'h2
`define MSD_BYTE_MASK 8'hF8
`define MSD_SFR_FLAG 7
`endif

/* msd_pkg.sv */
package msd_pkg;
	typedef enum logic [1:0] {
		ia_direct,
		ia_indirect,
		ia_reg,
		ia_bit
	} msd_ia_mode_e;
	typedef enum logic {
		xm_ri,
		xm_data_pointer_16
	} msd_xmode_e;
	typedef enum logic [1:0] {
		xs_idle,
		xs_c1,
		xs_c2
	} msd_xstate_e;
	typedef logic [7:0] msd_byte_t;
endpackage

/* msd_xram_if.sv */
`timescale 1ns/1ps
interface msd_xram_if #(
	parameter int AW = 8,
	parameter int DW = 8
);
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic we;
	logic [DW-1:0] rdata;
	modport host (output addr, output wdata, output we, input rdata);
	modport store (input addr, input wdata, input we, output rdata);
endinterface

/* msd_xram_store.sv */
`timescale 1ns/1ps
module msd_xram_store #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock
	input wire logic i_clk_sys,
	// Storage port
	msd_xram_if.store p
);
	logic [DW-1:0] mem_reg [2**AW];

	// No reset on purpose: contents ride through a system reset
	always_ff @(posedge i_clk_sys) begin
		if (p.we) begin
			mem_reg[p.addr] <= p.wdata;
		end
	end

	assign p.rdata = mem_reg[p.addr];
endmodule // msd_xram_store

/* msd_top.sv */
`timescale 1ns/1ps
`include "msd_params.svh"
module msd_top (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_mc_en,
	// Code fetch
	input wire logic i_external_access_select,
	input wire logic [15:0] i_fetch_addr,
	output logic o_fetch_internal,
	// Internal data access
	input wire logic i_ia_req,
	input wire msd_pkg::msd_ia_mode_e i_ia_mode,
	input wire logic i_ia_we,
	input wire logic [7:0] i_ia_addr,
	input wire logic i_ia_index_register,
	input wire logic [7:0] i_ia_wdata,
	output logic [7:0] o_ia_rdata,
	output logic o_sfr_sel,
	output logic o_sfr_area_select,
	// Stack
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [7:0] i_stack_wdata,
	output logic [7:0] o_stack_rdata,
	output logic [7:0] o_stack_pointer,
	output logic [1:0] o_bank_select,
	output logic o_onchip_ram_map_enable,
	// External move
	input wire logic i_xm_start,
	input wire msd_pkg::msd_xmode_e i_xm_mode,
	input wire logic i_xm_we,
	input wire logic i_xm_index_register,
	input wire logic [7:0] i_xm_wdata,
	input wire logic [15:0] i_data_pointer_16,
	input wire logic [7:0] i_p2_page,
	output logic o_xm_busy,
	output logic o_xm_done,
	output logic [7:0] o_xm_rdata,
	// Port pins
	input wire logic [7:0] i_p0_in,
	output logic [7:0] o_p0_out,
	output logic o_p0_oe_n,
	output logic [7:0] o_p2_out,
	output logic o_bus_own,
	output logic o_wr_n,
	output logic o_rd_n
);
	import msd_pkg::*;

	logic [7:0] iram_reg [256];
	logic [7:0] sp_reg;
	logic [7:0] psw_reg;
	logic [7:0] system_control_reg;
	logic [7:0] ia_rdata_reg;
	logic [7:0] stack_rdata_reg;
	msd_xstate_e xs_reg;
	msd_xstate_e xs_next;
	logic [15:0] xm_addr_reg;
	logic xm_onchip_reg;
	logic xm_we_reg;
	logic [7:0] xm_wdata_reg;
	logic [7:0] xm_rdata_reg;
	logic [7:0] p0_out_reg;
	logic [7:0] p0_out_next;
	logic p0_oe_n_reg;
	logic p0_oe_n_next;
	logic [7:0] p2_out_reg;
	logic [7:0] p2_out_next;
	logic bus_own_reg;
	logic bus_own_next;
	logic wr_n_reg;
	logic wr_n_next;
	logic rd_n_reg;
	logic rd_n_next;

	msd_xram_if #(.AW(8), .DW(8)) xram_bus ();

	msd_xram_store #(.AW(8), .DW(8)) u_xram (
		.i_clk_sys(i_clk_sys),
		.p(xram_bus.store)
	);

	// Code space steering
	wire fetch_low = i_fetch_addr < `MSD_CODE_LIMIT;
	assign o_fetch_internal = i_external_access_select & fetch_low;

	// Register bank and pointers
	wire [1:0] bank = {psw_reg[`MSD_BIT_RS1], psw_reg[`MSD_BIT_RS0]};
	wire [7:0] ia_ri_addr = {3'h0, bank, 2'h0, i_ia_index_register};
	wire [7:0] xm_ri_addr = {3'h0, bank, 2'h0, i_xm_index_register};
	wire [7:0] ia_ptr = iram_reg[ia_ri_addr];
	wire [7:0] xm_ptr = iram_reg[xm_ri_addr];
	wire [7:0] reg_addr = {3'h0, bank, i_ia_addr[2:0]};

	// Bit space: low half maps onto bytes 20..2F, high half onto SFR bytes
	wire bit_sfr = i_ia_addr[`MSD_SFR_FLAG];
	wire [7:0] bit_byte = bit_sfr ? (i_ia_addr & `MSD_BYTE_MASK)
		: {`MSD_BITAREA_HI, i_ia_addr[6:3]};

	logic [7:0] eff_addr;
	always_comb begin
		unique case (i_ia_mode)
			ia_direct: eff_addr = i_ia_addr;
			ia_indirect: eff_addr = ia_ptr;
			ia_reg: eff_addr = reg_addr;
			ia_bit: eff_addr = bit_byte;
		endcase
	end

	// Shared upper addresses split by addressing mode
	wire direct_kind = (i_ia_mode == ia_direct) | (i_ia_mode == ia_bit);
	wire is_sfr = direct_kind & eff_addr[`MSD_SFR_FLAG];
	wire hit_sp = is_sfr & (eff_addr == `MSD_ADDR_SP);
	wire hit_system_control = is_sfr & (eff_addr == `MSD_ADDR_SYSTEM_CONTROL);
	wire hit_psw = is_sfr & (eff_addr == `MSD_ADDR_PSW);
	wire hit_local = hit_sp | hit_system_control | hit_psw;
	// Other SFRs live outside; the area bit tells them which map to decode
	assign o_sfr_sel = i_ia_req & is_sfr & ~hit_local;
	assign o_sfr_area_select = system_control_reg[`MSD_BIT_SFR_AREA_SELECT];

	wire [7:0] system_control_view = system_control_reg & `MSD_SYSTEM_CONTROL_MASK;
	wire [7:0] sfr_rdata = hit_sp ? sp_reg : hit_psw ? psw_reg
		: hit_system_control ? system_control_view : 8'h00;
	wire [7:0] byte_rdata = is_sfr ? sfr_rdata : iram_reg[eff_addr];
	wire bit_rval = byte_rdata[i_ia_addr[2:0]];

	// Bit write rewrites one bit of the addressed byte
	logic [7:0] bit_merge;
	always_comb begin
		bit_merge = byte_rdata;
		bit_merge[i_ia_addr[2:0]] = i_ia_wdata[0];
	end
	wire is_bit = i_ia_mode == ia_bit;
	wire [7:0] ia_wval = is_bit ? bit_merge : i_ia_wdata;
	wire [7:0] ia_rval = is_bit ? {7'h00, bit_rval} : byte_rdata;

	// Stack takes the single RAM write port over a plain access
	wire stack_op = i_push | i_pop;
	wire ia_go = i_ia_req & ~stack_op;
	wire ia_wr = ia_go & i_ia_we;
	wire [7:0] sp_inc = sp_reg + 8'h01;
	wire [7:0] sp_dec = sp_reg - 8'h01;
	wire iram_we = i_push | (ia_wr & ~is_sfr);
	wire [7:0] iram_waddr = i_push ? sp_inc : eff_addr;
	wire [7:0] iram_wdata = i_push ? i_stack_wdata : ia_wval;

	always_ff @(posedge i_clk_sys) begin
		if (iram_we) begin
			iram_reg[iram_waddr] <= iram_wdata;
		end
	end

	// Stack pointer and local SFRs
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sp_reg <= `MSD_SP_RESET;
		end else if (i_push) begin
			sp_reg <= sp_inc;
		end else if (i_pop) begin
			sp_reg <= sp_dec;
		end else if (ia_wr & hit_sp) begin
			sp_reg <= ia_wval;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			psw_reg <= `MSD_PSW_RESET;
		end else if (ia_wr & hit_psw) begin
			psw_reg <= ia_wval;
		end
	end

	// Area select changes only at reset or on a software write
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			system_control_reg <= `MSD_SYSTEM_CONTROL_RESET;
		end else if (ia_wr & hit_system_control) begin
			// Reserved bit 5 keeps reading one whatever software writes
			system_control_reg <= (ia_wval & `MSD_SYSTEM_CONTROL_MASK)
				| `MSD_SYSTEM_CONTROL_RESET;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ia_rdata_reg <= 8'h00;
			stack_rdata_reg <= 8'h00;
		end else begin
			if (ia_go) begin
				ia_rdata_reg <= ia_rval;
			end
			if (i_pop & ~i_push) begin
				stack_rdata_reg <= iram_reg[sp_reg];
			end
		end
	end

	assign o_ia_rdata = ia_rdata_reg;
	assign o_stack_rdata = stack_rdata_reg;
	assign o_stack_pointer = sp_reg;
	assign o_bank_select = bank;
	wire map_en = system_control_reg[`MSD_BIT_ONCHIP_RAM_MAP_ENABLE];
	assign o_onchip_ram_map_enable = map_en;

	// External move: address and target fixed when the move is taken
	wire xm_take = i_mc_en & i_xm_start & (xs_reg == xs_idle);
	wire xm_is_ri = i_xm_mode == xm_ri;
	wire [15:0] xm_addr = xm_is_ri ? {i_p2_page, xm_ptr}
		: i_data_pointer_16;
	wire data_pointer_16_top = i_data_pointer_16[15:8] == `MSD_XRAM_PAGE;
	wire xm_onchip = map_en & (xm_is_ri | data_pointer_16_top);
	wire in_c1 = xs_reg == xs_c1;
	wire in_c2 = xs_reg == xs_c2;
	// Second cycle commits even when reset arrives with it
	wire xm_commit = in_c2 & (i_mc_en | i_sys_rst);
	wire ext_read_done = in_c2 & i_mc_en & ~xm_onchip_reg & ~xm_we_reg;

	assign xram_bus.addr = xm_addr_reg[7:0];
	assign xram_bus.wdata = xm_wdata_reg;
	assign xram_bus.we = xm_commit & xm_we_reg & xm_onchip_reg;

	always_comb begin
		xs_next = xs_reg;
		p0_out_next = p0_out_reg;
		p0_oe_n_next = p0_oe_n_reg;
		p2_out_next = p2_out_reg;
		bus_own_next = bus_own_reg;
		wr_n_next = wr_n_reg;
		rd_n_next = rd_n_reg;
		unique case (xs_reg)
			xs_idle: begin
				if (xm_take) begin
					xs_next = xs_c1;
					if (~xm_onchip) begin
						bus_own_next = 1'b1;
						p0_out_next = xm_addr[7:0];
						p0_oe_n_next = 1'b0;
						p2_out_next = xm_addr[15:8];
					end
				end
			end
			xs_c1: begin
				if (i_mc_en) begin
					xs_next = xs_c2;
					if (~xm_onchip_reg & xm_we_reg) begin
						p0_out_next = xm_wdata_reg;
						wr_n_next = 1'b0;
					end else if (~xm_onchip_reg) begin
						p0_oe_n_next = 1'b1;
						rd_n_next = 1'b0;
					end
				end
			end
			xs_c2: begin
				if (i_mc_en) begin
					xs_next = xs_idle;
					bus_own_next = 1'b0;
					p0_oe_n_next = 1'b1;
					wr_n_next = 1'b1;
					rd_n_next = 1'b1;
				end
			end
			default: xs_next = xs_idle;
		endcase
	end

	// Reset in the first cycle drops the move before anything is stored
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			xs_reg <= xs_idle;
			bus_own_reg <= 1'b0;
			p0_oe_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			p0_out_reg <= 8'h00;
			p2_out_reg <= 8'h00;
		end else begin
			xs_reg <= xs_next;
			bus_own_reg <= bus_own_next;
			p0_oe_n_reg <= p0_oe_n_next;
			wr_n_reg <= wr_n_next;
			rd_n_reg <= rd_n_next;
			p0_out_reg <= p0_out_next;
			p2_out_reg <= p2_out_next;
		end
	end

	// Move context is kept across reset so a second-cycle write lands
	always_ff @(posedge i_clk_sys) begin
		if (xm_take) begin
			xm_addr_reg <= xm_addr;
			xm_onchip_reg <= xm_onchip;
			xm_we_reg <= i_xm_we;
			xm_wdata_reg <= i_xm_wdata;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			xm_rdata_reg <= 8'h00;
		end else if (in_c2 & i_mc_en & ~xm_we_reg & xm_onchip_reg) begin
			xm_rdata_reg <= xram_bus.rdata;
		end else if (ext_read_done) begin
			xm_rdata_reg <= i_p0_in;
		end
	end

	assign o_xm_busy = in_c1 | in_c2;
	assign o_xm_done = in_c2 & i_mc_en & ~i_sys_rst;
	assign o_xm_rdata = xm_rdata_reg;
	assign o_p0_out = p0_out_reg;
	assign o_p0_oe_n = p0_oe_n_reg;
	assign o_p2_out = p2_out_reg;
	assign o_bus_own = bus_own_reg;
	assign o_wr_n = wr_n_reg;
	assign o_rd_n = rd_n_reg;
endmodule // msd_top

/* msd_ext_mem.sv */
`timescale 1ns/1ps
module msd_ext_mem (
	// Bus pins
	input wire logic i_clk_sys,
	input wire logic [7:0] i_p0,
	input wire logic [7:0] i_p2,
	input wire logic i_oe_n,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	// Back to the design
	output logic [7:0] o_p0,
	output logic [15:0] o_addr
);
	logic [7:0] mem [65536];
	logic [7:0] last_rd = 8'h00;
	always @(posedge i_clk_sys) begin
		if (!i_oe_n && i_wr_n && i_rd_n)
			o_addr <= {i_p2, i_p0};
		if (!i_wr_n)
			mem[o_addr] <= i_p0;
		if (!i_rd_n)
			last_rd <= mem[o_addr];
	end
	// Released port 0 shows the inverse of its last byte, so stale data fails
	assign o_p0 = !i_rd_n ? mem[o_addr] : ~last_rd;
endmodule // msd_ext_mem

/* msd_top_monitor.sv */
`timescale 1ns/1ps
module msd_top_monitor (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_mc_en,
	// Watched ports
	input wire logic i_external_access_select,
	input wire logic [15:0] i_fetch_addr,
	input wire logic o_fetch_internal,
	input wire logic i_ia_req,
	input wire logic i_ia_we,
	input wire logic i_push,
	input wire logic [7:0] o_stack_pointer,
	input wire logic o_sfr_area_select,
	input wire logic o_onchip_ram_map_enable,
	input wire logic i_xm_start,
	input wire msd_pkg::msd_xmode_e i_xm_mode,
	input wire logic [15:0] i_data_pointer_16,
	input wire logic o_xm_busy,
	input wire logic o_xm_done,
	input wire logic o_bus_own,
	input wire logic o_p0_oe_n
);
	import msd_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	wire taken = i_mc_en && i_xm_start && !o_xm_busy;
	wire onchip = o_onchip_ram_map_enable &&
		(i_xm_mode == xm_ri || i_data_pointer_16[15:8] == 8'hFF);
	chk_fetch_route: assert property (
		o_fetch_internal == (i_external_access_select &&
		i_fetch_addr < 16'h4000)) else $error("fetch route");
	chk_sp_reset: assert property (disable iff (1'b0)
		i_sys_rst |=> o_stack_pointer == 8'h07) else $error("sp reset");
	chk_map_reset: assert property (disable iff (1'b0)
		i_sys_rst |=> !o_onchip_ram_map_enable) else $error("map reset");
	chk_push_step: assert property (
		i_push |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
		else $error("push step");
	chk_onchip_quiet: assert property (
		taken && onchip |=> !o_bus_own [*3]) else $error("bus used");
	chk_ext_bus: assert property (
		taken && !onchip |=> o_bus_own && !o_p0_oe_n) else $error("no bus");
	chk_two_cycle: assert property (
		taken ##1 i_mc_en |-> !o_xm_done ##1 (o_xm_done || !i_mc_en))
		else $error("move length");
	chk_area_hold: assert property (
		o_sfr_area_select && !(i_ia_req && i_ia_we) |=> o_sfr_area_select)
		else $error("area select lost");
	cover property (taken && onchip);
	cover property (taken && !onchip);
	cover property (disable iff (1'b0) o_xm_busy && i_sys_rst);
endmodule // msd_top_monitor
bind msd_top msd_top_monitor u_msd_top_monitor (
	.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst),
	.i_mc_en(i_mc_en),
	.i_external_access_select(i_external_access_select),
	.i_fetch_addr(i_fetch_addr),
	.o_fetch_internal(o_fetch_internal),
	.i_ia_req(i_ia_req),
	.i_ia_we(i_ia_we),
	.i_push(i_push),
	.o_stack_pointer(o_stack_pointer),
	.o_sfr_area_select(o_sfr_area_select),
	.o_onchip_ram_map_enable(o_onchip_ram_map_enable),
	.i_xm_start(i_xm_start),
	.i_xm_mode(i_xm_mode),
	.i_data_pointer_16(i_data_pointer_16),
	.o_xm_busy(o_xm_busy),
	.o_xm_done(o_xm_done),
	.o_bus_own(o_bus_own),
	.o_p0_oe_n(o_p0_oe_n)
);

/* msd_top_tb.sv */
`timescale 1ns/1ps
module msd_top_tb;
	import msd_pkg::*;
	logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_mc_en = 1'b1;
	logic i_external_access_select = 1'b0, i_ia_req = 1'b0, i_ia_we = 1'b0;
	logic i_ia_index_register = 1'b0, i_xm_index_register = 1'b0;
	logic i_push = 1'b0, i_pop = 1'b0, i_xm_start = 1'b0, i_xm_we = 1'b0;
	msd_ia_mode_e i_ia_mode = ia_direct;
	msd_xmode_e i_xm_mode = xm_ri;
	logic [7:0] i_ia_addr = 8'h00, i_ia_wdata = 8'h00, i_stack_wdata = 8'h00;
	logic [7:0] i_xm_wdata = 8'h00, i_p2_page = 8'h00, i_p0_in, mdl_p0;
	logic [15:0] i_fetch_addr = 16'h0000, i_data_pointer_16 = 16'h0000;
	logic o_fetch_internal, o_sfr_sel, o_sfr_area_select, o_xm_busy, o_rd_n;
	logic o_onchip_ram_map_enable, o_xm_done, o_p0_oe_n, o_bus_own, o_wr_n;
	logic [1:0] o_bank_select;
	logic [7:0] o_ia_rdata, o_stack_rdata, o_stack_pointer, o_xm_rdata;
	logic [7:0] o_p0_out, o_p2_out;
	logic [15:0] ext_addr;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	// Port 0 level: the design while it drives, else the memory model
	assign i_p0_in = o_p0_oe_n ? mdl_p0 : o_p0_out;
	msd_top u_msd_top (.*);
	msd_ext_mem u_msd_ext_mem (.i_clk_sys(i_clk_sys), .i_p0(i_p0_in),
		.i_p2(o_p2_out), .i_oe_n(o_p0_oe_n), .i_wr_n(o_wr_n),
		.i_rd_n(o_rd_n), .o_p0(mdl_p0), .o_addr(ext_addr));
	initial forever #20 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic step();
		@(posedge i_clk_sys);
		#1;
	endtask
	task automatic ia(input msd_ia_mode_e m, input logic w,
		input logic [7:0] a, input logic [7:0] d);
		i_ia_mode = m;
		i_ia_we = w;
		i_ia_addr = a;
		i_ia_wdata = d;
		i_ia_req = 1'b1;
		step();
		i_ia_req = 1'b0;
		step();
	endtask
	// Reset code 1 or 2 pulses reset in the first or second move cycle
	task automatic xm(input msd_xmode_e m, input logic w,
		input logic [15:0] dp, input logic [7:0] d, input int rc);
		i_xm_mode = m;
		i_xm_we = w;
		i_data_pointer_16 = dp;
		i_xm_wdata = d;
		i_xm_start = 1'b1;
		step();
		chk("busy", 1, o_xm_busy);
		i_xm_start = 1'b0;
		i_sys_rst = (rc == 1);
		step();
		i_sys_rst = (rc == 2);
		if (rc == 0)
			chk("done", 1, o_xm_done);
		step();
		i_sys_rst = 1'b0;
		step();
	endtask
	task automatic t_fetch();
		for (int i = 0; i < 4; i++) begin
			i_external_access_select = i[1];
			i_fetch_addr = i[0] ? 16'h4000 : 16'h3FFF;
			#1 chk("fetch", i == 2, o_fetch_internal);
			step();
		end
		$display("fetch test done");
	endtask
	task automatic t_regs();
		ia(ia_direct, 1'b0, 8'h81, 8'h00);
		chk("sp", 8'h07, o_ia_rdata);
		ia(ia_direct, 1'b0, 8'hB1, 8'h00);
		chk("system_control", 8'h20, o_ia_rdata);
		ia(ia_direct, 1'b1, 8'hD0, 8'h10);
		chk("bank", 2'h2, o_bank_select);
		ia(ia_reg, 1'b1, 8'h00, 8'h40);
		ia(ia_direct, 1'b0, 8'h10, 8'h00);
		chk("bank_r0", 8'h40, o_ia_rdata);
		ia(ia_indirect, 1'b1, 8'h00, 8'h5A);
		ia(ia_direct, 1'b0, 8'h40, 8'h00);
		chk("indirect", 8'h5A, o_ia_rdata);
		ia(ia_reg, 1'b1, 8'h00, 8'h90);
		ia(ia_indirect, 1'b1, 8'h00, 8'h77);
		ia(ia_indirect, 1'b0, 8'h00, 8'h00);
		chk("upper", 8'h77, o_ia_rdata);
		i_ia_mode = ia_direct;
		i_ia_addr = 8'h90;
		i_ia_req = 1'b1;
		#1 chk("sfr_sel", 1, o_sfr_sel);
		step();
		i_ia_req = 1'b0;
		step();
		ia(ia_direct, 1'b1, 8'h21, 8'h00);
		ia(ia_bit, 1'b1, 8'h0A, 8'h01);
		ia(ia_direct, 1'b0, 8'h21, 8'h00);
		chk("bit", 8'h04, o_ia_rdata);
		ia(ia_direct, 1'b1, 8'hD0, 8'h00);
		$display("register test done");
	endtask
	task automatic t_stack();
		i_push = 1'b1;
		i_stack_wdata = 8'hC3;
		step();
		i_push = 1'b0;
		chk("sp_push", 8'h08, o_stack_pointer);
		ia(ia_direct, 1'b0, 8'h08, 8'h00);
		chk("push_loc", 8'hC3, o_ia_rdata);
		i_pop = 1'b1;
		step();
		i_pop = 1'b0;
		chk("pop", 8'hC3, o_stack_rdata);
		step();
		$display("stack test done");
	endtask
	task automatic t_moves();
		ia(ia_reg, 1'b1, 8'h00, 8'h34);
		i_p2_page = 8'h12;
		xm(xm_ri, 1'b1, 16'h0000, 8'h9C, 0);
		chk("ext_addr", 16'h1234, ext_addr);
		xm(xm_ri, 1'b0, 16'h0000, 8'h00, 0);
		chk("ext_rd", 8'h9C, o_xm_rdata);
		ia(ia_direct, 1'b1, 8'hB1, 8'h11);
		chk("map_on", 1, o_onchip_ram_map_enable);
		chk("sfr_area_select", 1, o_sfr_area_select);
		xm(xm_ri, 1'b1, 16'h0000, 8'h5E, 0);
		xm(xm_data_pointer_16, 1'b0, 16'hFF34, 8'h00, 0);
		chk("xram_rd", 8'h5E, o_xm_rdata);
		chk("no_bus", 16'h1234, ext_addr);
		xm(xm_data_pointer_16, 1'b1, 16'hFE00, 8'h66, 0);
		chk("data_pointer_16_ext", 16'hFE00, ext_addr);
		ia(ia_direct, 1'b0, 8'hB1, 8'h00);
		chk("system_control_rd", 8'h31, o_ia_rdata);
		$display("move test done");
	endtask
	task automatic t_rst();
		xm(xm_ri, 1'b1, 16'h0000, 8'hA1, 1);
		chk("map_rst", 0, o_onchip_ram_map_enable);
		ia(ia_direct, 1'b1, 8'hB1, 8'h01);
		xm(xm_ri, 1'b0, 16'h0000, 8'h00, 0);
		chk("rst_c1", 8'h5E, o_xm_rdata);
		xm(xm_ri, 1'b1, 16'h0000, 8'hA1, 2);
		ia(ia_direct, 1'b1, 8'hB1, 8'h01);
		xm(xm_ri, 1'b0, 16'h0000, 8'h00, 0);
		chk("rst_c2", 8'hA1, o_xm_rdata);
		$display("reset test done");
	endtask
	// A missing machine-cycle pulse stretches the first move cycle
	task automatic t_slow();
		i_xm_mode = xm_data_pointer_16;
		i_xm_we = 1'b0;
		i_data_pointer_16 = 16'hFF34;
		i_xm_start = 1'b1;
		step();
		i_xm_start = 1'b0;
		i_mc_en = 1'b0;
		step();
		chk("slow_busy", 1, o_xm_busy);
		chk("slow_c1", 0, o_xm_done);
		i_mc_en = 1'b1;
		step();
		chk("slow_done", 1, o_xm_done);
		step();
		chk("slow_rd", 8'hA1, o_xm_rdata);
		chk("slow_idle", 0, o_xm_busy);
		$display("slow move test done");
	endtask
	initial begin
		repeat (3) @(posedge i_clk_sys);
		#1 i_sys_rst = 1'b0;
		t_fetch();
		t_regs();
		t_stack();
		t_moves();
		t_rst();
		t_slow();
		end_sim();
	end
endmodule // msd_top_tb
